// file: wwdt_pkg.sv
// Constants shared by the windowed watchdog files
package wwdt_pkg;

  // Register byte offsets
  localparam logic [3:0]  WWDT_CONTROL_OFS   = 4'h0;
  localparam logic [3:0]  WWDT_MODE_OFS      = 4'h4;
  localparam logic [3:0]  WWDT_STATUS_OFS    = 4'h8;

  // Control register fields
  localparam int          WWDT_CR_RESTART    = 0;
  localparam int          WWDT_CR_KEY_LSB    = 24;
  localparam logic [7:0]  WWDT_KEY_VALUE     = 8'hA5;

  // Mode register fields
  localparam int          WWDT_MR_LOAD_LSB   = 0;
  localparam int          WWDT_MR_FIEN       = 12;
  localparam int          WWDT_MR_RSTEN      = 13;
  localparam int          WWDT_MR_RPROC      = 14;
  localparam int          WWDT_MR_OFF        = 15;
  localparam int          WWDT_MR_DELTA_LSB  = 16;
  localparam int          WWDT_MR_DBGHLT     = 28;
  localparam int          WWDT_MR_IDLEHLT    = 29;
  localparam logic [31:0] WWDT_MR_WR_MASK    = 32'h3FFF_FFFF;
  localparam logic [31:0] WWDT_MR_RESET      = 32'h3FFF_2FFF;

  // Status register fields
  localparam int          WWDT_SR_UNF        = 0;
  localparam int          WWDT_SR_ERR        = 1;

  // Counter and prescaler
  localparam int          WWDT_CNT_W         = 12;
  localparam int          WWDT_PRESCALE_DIV  = 128;

endpackage : wwdt_pkg

// file: wwdt_prescaler.sv
// Slow clock prescaler producing one counter tick per DIV slow ticks
`timescale 1ns/10ps
`default_nettype none

module wwdt_prescaler
  import wwdt_pkg::*;
#(
  parameter int DIV = WWDT_PRESCALE_DIV
) (
  // Clock and reset
  input  wire logic clk_i,
  input  wire logic rst_i,
  // Control
  input  wire logic slow_en_i,
  input  wire logic run_i,
  input  wire logic clear_i,
  // Tick out
  output logic      tick_o
);

  localparam int W = $clog2(DIV);

  logic [W-1:0] cnt_q;
  logic [W-1:0] cnt_d;
  logic         tick_d;
  logic         wrap;

  // Refused at elaboration, a divider below two has no wrap point
  if (DIV < 2) begin : g_div_check
    $error("wwdt_prescaler: DIV must be at least 2");
  end

  assign wrap   = (cnt_q == W'(DIV - 1));
  assign tick_d = !clear_i && run_i && slow_en_i && wrap;

  always_comb begin
    cnt_d = cnt_q;
    if (clear_i) begin
      cnt_d = '0;
    end else if (run_i && slow_en_i) begin
      cnt_d = wrap ? '0 : cnt_q + W'(1);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_q  <= '0;
      tick_o <= 1'b0;
    end else begin
      cnt_q  <= cnt_d;
      tick_o <= tick_d;
    end
  end

endmodule : wwdt_prescaler

`default_nettype wire

// file: wwdt_top.sv
// Windowed watchdog timer with a classic Wishbone register slave
// Behaviour
// [RULE1] Watchdog is a 12-bit down counter loaded from the mode load field.
// [RULE2] Counter decrements once per 128 slow clock ticks.
// [RULE3] After reset the load field is 0xFFF and fault reset is enabled.
// [RULE4] Processor reset returns every watchdog state to initial values.
// [RULE5] Only the first mode write is taken; reset alone clears the lock.
// [RULE6] An accepted mode write reloads and restarts the counter.
// [RULE7] Keyed restart reloads the counter and restarts the prescaler.
// [RULE8] Control writes without the correct key change nothing.
// [RULE9] Software writes key 0xA5 with every control write.
// [RULE10] Underflow sets sticky flag; fault line only with fault reset enabled.
// [RULE11] Restart honoured only while counter lies in zero to delta.
// [RULE12] Restart above delta sets error flag and fault, even when off.
// [RULE13] Delta at or above load value allows restart anywhere without error.
// [RULE14] Interrupt from either flag only while fault interrupt enabled.
// [RULE15] Fault line with reset enable drives a reset that clears everything.
// [RULE16] Status read or reset clears flags, interrupt and fault line.
// [RULE17] Fault may request a general reset or a processor-only reset.
// [RULE18] Select bit zero requests all resets, one only processor reset.
// [RULE19] Counter halts in debug or idle state when the halt bit is set.
// [RULE20] Off bit in mode register stops the watchdog.
// [RULE21] Tick at zero signals underflow; counter then holds at zero.
`timescale 1ns/10ps
`default_nettype none

module wwdt_top
  import wwdt_pkg::*;
(
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // Wishbone classic slave
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [3:0]  adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  output logic      [31:0] dat_o,
  output logic             ack_o,
  // Slow clock pin and processor state
  input  wire logic        slow_clk_i,
  input  wire logic        debug_state_i,
  input  wire logic        idle_mode_i,
  // Fault signalling
  output logic             fault_o,
  output logic             irq_o,
  output logic             all_reset_req_o,
  output logic             proc_reset_req_o
);

  // Slow clock pin synchroniser and edge detect
  logic slow_meta_q;
  logic slow_sync_q;
  logic slow_prev_q;
  logic slow_en;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      slow_meta_q <= 1'b0;
      slow_sync_q <= 1'b0;
      slow_prev_q <= 1'b0;
    end else begin
      slow_meta_q <= slow_clk_i;
      slow_sync_q <= slow_meta_q;
      slow_prev_q <= slow_sync_q;
    end
  end

  assign slow_en = slow_sync_q && !slow_prev_q;

  // Bus decode; a write or read takes effect on the edge where ack is seen high
  logic        bus_req;
  logic        bus_fire;
  logic        hit_control;
  logic        hit_mode;
  logic        hit_status;
  logic [31:0] byte_mask;

  assign bus_req  = cyc_i && stb_i;
  assign bus_fire = bus_req && ack_o;

  assign hit_control = (adr_i == WWDT_CONTROL_OFS);
  assign hit_mode    = (adr_i == WWDT_MODE_OFS);
  assign hit_status  = (adr_i == WWDT_STATUS_OFS);

  assign byte_mask = {{8{sel_i[3]}}, {8{sel_i[2]}}, {8{sel_i[1]}}, {8{sel_i[0]}}};

  // Mode register and its write-once lock
  logic [31:0] mode_q;
  logic [31:0] mode_d;
  logic        mode_lock_q;
  logic        mode_wr;

  assign mode_wr = bus_fire && we_i && hit_mode && !mode_lock_q;       // [RULE5]
  assign mode_d  = ((mode_q & ~byte_mask) | (dat_i & byte_mask)) & WWDT_MR_WR_MASK;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mode_q      <= WWDT_MR_RESET;                                    // [RULE3] [RULE4]
      mode_lock_q <= 1'b0;                                             // [RULE5]
    end else if (mode_wr) begin
      mode_q      <= mode_d;
      mode_lock_q <= 1'b1;                                             // [RULE5]
    end
  end

  // Mode fields
  logic [WWDT_CNT_W-1:0] counter_load_value;
  logic [WWDT_CNT_W-1:0] restart_window_delta;
  logic                  fault_interrupt_enable;
  logic                  fault_reset_enable;
  logic                  processor_only_reset_select;
  logic                  watchdog_off_bit;
  logic                  debug_halt_bit;
  logic                  idle_halt_bit;

  assign counter_load_value          = mode_q[WWDT_MR_LOAD_LSB +: WWDT_CNT_W];
  assign restart_window_delta        = mode_q[WWDT_MR_DELTA_LSB +: WWDT_CNT_W];
  assign fault_interrupt_enable      = mode_q[WWDT_MR_FIEN];
  assign fault_reset_enable          = mode_q[WWDT_MR_RSTEN];
  assign processor_only_reset_select = mode_q[WWDT_MR_RPROC];
  assign watchdog_off_bit            = mode_q[WWDT_MR_OFF];
  assign debug_halt_bit              = mode_q[WWDT_MR_DBGHLT];
  assign idle_halt_bit               = mode_q[WWDT_MR_IDLEHLT];

  // Keyed control write
  logic                  key_ok;
  logic                  restart_req;
  logic                  in_window;
  logic                  restart_ok;
  logic                  window_error;
  logic [WWDT_CNT_W-1:0] cnt_q;

  // Key byte must be written as a whole, so lane 3 must be enabled
  assign key_ok      = sel_i[3] && (dat_i[WWDT_CR_KEY_LSB +: 8] == WWDT_KEY_VALUE);  // [RULE8] [RULE9]
  assign restart_req = bus_fire && we_i && hit_control && key_ok
                       && sel_i[0] && dat_i[WWDT_CR_RESTART];                         // [RULE8]
  // Delta at or above the load value makes the window cover every count
  assign in_window    = (cnt_q <= restart_window_delta);                // [RULE11] [RULE13]
  assign restart_ok   = restart_req && in_window;                       // [RULE11]
  assign window_error = restart_req && !in_window;                      // [RULE12]

  // Counter run conditions and prescaler
  logic run;
  logic reload;
  logic cnt_tick;

  assign run = !watchdog_off_bit                                        // [RULE20]
               && !(debug_halt_bit && debug_state_i)                    // [RULE19]
               && !(idle_halt_bit && idle_mode_i);                      // [RULE19]

  assign reload = mode_wr || restart_ok;                                // [RULE6] [RULE7]

  wwdt_prescaler #(
    .DIV       (WWDT_PRESCALE_DIV)
  ) u_prescaler (
    .clk_i     (clk_i),
    .rst_i     (rst_i),
    .slow_en_i (slow_en),
    .run_i     (run),
    .clear_i   (reload),                                                // [RULE7]
    .tick_o    (cnt_tick)                                               // [RULE2]
  );

  // Down counter
  logic [WWDT_CNT_W-1:0] cnt_d;
  logic                  underflow;
  logic                  cnt_zero;

  assign cnt_zero  = (cnt_q == '0);
  // Tick is gated by run again, since run may fall after the tick was issued
  assign underflow = cnt_tick && run && cnt_zero && !reload;            // [RULE21]

  always_comb begin
    cnt_d = cnt_q;
    if (mode_wr) begin
      cnt_d = mode_d[WWDT_MR_LOAD_LSB +: WWDT_CNT_W];                   // [RULE6]
    end else if (restart_ok) begin
      cnt_d = counter_load_value;                                       // [RULE7]
    end else if (cnt_tick && run && !cnt_zero) begin
      cnt_d = cnt_q - WWDT_CNT_W'(1);                                   // [RULE1] [RULE21]
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_q <= WWDT_MR_RESET[WWDT_MR_LOAD_LSB +: WWDT_CNT_W];           // [RULE3] [RULE4]
    end else begin
      cnt_q <= cnt_d;
    end
  end

  // Sticky flags; a new event in the clearing cycle survives the clear
  logic status_rd;
  logic underflow_flag_q;
  logic window_error_flag_q;
  logic fault_q;
  logic fault_set;

  assign status_rd = bus_fire && !we_i && hit_status;                   // [RULE16]
  assign fault_set = (underflow && fault_reset_enable) || window_error; // [RULE10] [RULE12]

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      underflow_flag_q    <= 1'b0;                                      // [RULE15] [RULE16]
      window_error_flag_q <= 1'b0;
      fault_q             <= 1'b0;
    end else begin
      // Flag bits clear only where the read returned them, so a flag raised mid-read is kept; fault_q clears on any status read
      underflow_flag_q    <= underflow || (underflow_flag_q && !(status_rd && dat_o[WWDT_SR_UNF]));      // [RULE10] [RULE16]
      window_error_flag_q <= window_error || (window_error_flag_q && !(status_rd && dat_o[WWDT_SR_ERR])); // [RULE12] [RULE16]
      fault_q             <= fault_set || (fault_q && !status_rd);                // [RULE16]
    end
  end

  // Registered outputs
  logic irq_d;
  logic all_reset_d;
  logic proc_reset_d;

  assign irq_d        = fault_interrupt_enable && (underflow_flag_q || window_error_flag_q);  // [RULE14]
  assign all_reset_d  = fault_q && fault_reset_enable && !processor_only_reset_select;      // [RULE17] [RULE18]
  assign proc_reset_d = fault_q && fault_reset_enable && processor_only_reset_select;       // [RULE15] [RULE18]

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      fault_o          <= 1'b0;
      irq_o            <= 1'b0;
      all_reset_req_o  <= 1'b0;
      proc_reset_req_o <= 1'b0;
    end else begin
      fault_o          <= fault_q && !status_rd;                        // [RULE16]
      irq_o            <= irq_d && !status_rd;                          // [RULE16]
      all_reset_req_o  <= all_reset_d && !status_rd;
      proc_reset_req_o <= proc_reset_d && !status_rd;
    end
  end

  // Read data and acknowledge
  logic [31:0] rd_data;

  assign rd_data = hit_mode   ? mode_q :
                   hit_status ? {30'h0, window_error_flag_q, underflow_flag_q} :
                   32'h0;

  // Ack lasts one cycle, so every access takes exactly two clock edges
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
      dat_o <= 32'h0;
    end else begin
      ack_o <= bus_req && !ack_o;
      dat_o <= (bus_req && !ack_o && !we_i) ? rd_data : 32'h0;
    end
  end

endmodule : wwdt_top

`default_nettype wire

// file: wwdt_checker.sv
// Assertions on the watchdog top ports
`timescale 1ns/10ps
`default_nettype none

module wwdt_checker
  import wwdt_pkg::*;
(
  // Watched ports
  input wire logic        clk_i, rst_i, cyc_i, stb_i, we_i,
  input wire logic [3:0]  adr_i, sel_i,
  input wire logic [31:0] dat_i, dat_o,
  input wire logic        ack_o, slow_clk_i, debug_state_i, idle_mode_i,
  input wire logic        fault_o, irq_o, all_reset_req_o, proc_reset_req_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);

  wire rd_status = cyc_i && stb_i && ack_o && !we_i && adr_i == WWDT_STATUS_OFS;

  sequence s_req;
    cyc_i && stb_i && !ack_o;
  endsequence

  a_ack_answers: assert property (s_req |=> ack_o) else $error("no ack after request");
  a_ack_single: assert property (ack_o |=> !ack_o) else $error("ack longer than one cycle");
  a_ack_no_req: assert property (!(cyc_i && stb_i) |=> !ack_o) else $error("ack without request");
  a_dat_idle: assert property (!ack_o |-> dat_o == 32'h0) else $error("read data outside ack");
  a_all_scope: assert property (all_reset_req_o |-> fault_o && !proc_reset_req_o)
    else $error("general reset request without fault");
  a_proc_scope: assert property (proc_reset_req_o |-> fault_o && !all_reset_req_o)
    else $error("processor reset request without fault");
  a_read_clears: assert property (rd_status |=> !fault_o && !irq_o)
    else $error("status read left fault or interrupt");
  a_fault_sticky: assert property (fault_o && !rd_status |=> fault_o)
    else $error("fault dropped without status read");
  a_irq_sticky: assert property (irq_o && !rd_status |=> irq_o)
    else $error("interrupt dropped without status read");
  a_reset_quiet: assert property ($fell(rst_i) |-> !fault_o && !irq_o && !ack_o)
    else $error("outputs active after reset");
endmodule : wwdt_checker

bind wwdt_top wwdt_checker u_chk (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
  .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .slow_clk_i(slow_clk_i),
  .debug_state_i(debug_state_i), .idle_mode_i(idle_mode_i), .fault_o(fault_o), .irq_o(irq_o),
  .all_reset_req_o(all_reset_req_o), .proc_reset_req_o(proc_reset_req_o));
`default_nettype wire

// file: wwdt_far_model.sv
// Far side: slow clock source and reset controller
`timescale 1ns/10ps
`default_nettype none

module wwdt_far_model (
  // Clock and control
  input  wire logic clk_i,
  input  wire logic boot_i,
  input  wire logic react_i,
  // Reset requests
  input  wire logic all_req_i,
  input  wire logic proc_req_i,
  // To the watchdog
  output var  logic slow_clk_o,
  output var  logic rst_o
);
  initial slow_clk_o = 1'b0;
  initial rst_o = 1'b1;
  // Far slower than clk_i so the synchroniser never drops an edge
  always #100 slow_clk_o = ~slow_clk_o;
  // Either scope resets the whole watchdog here
  always @(posedge clk_i) rst_o <= boot_i | (react_i & (all_req_i | proc_req_i));
endmodule : wwdt_far_model
`default_nettype wire

// file: tb_top.sv
// Self-checking bench for the windowed watchdog
`timescale 1ns/10ps
`default_nettype none

module tb_top;
  import wwdt_pkg::*;
  logic        clk_i = 1'b0, boot = 1'b1, react = 1'b0;
  logic        cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0;
  logic        debug_state_i = 1'b0, idle_mode_i = 1'b0;
  logic [3:0]  adr_i = 4'h0, sel_i = 4'hF;
  logic [31:0] dat_i = 32'h0, rd;
  logic [7:0]  bad_keys [3] = '{8'h00, 8'h5A, 8'hA4};
  wire logic   rst_i, slow_clk_i, ack_o, fault_o, irq_o, all_reset_req_o, proc_reset_req_o;
  wire logic [31:0] dat_o;
  int          bad_count = 0, compares = 0, cycles = 0;

  always #25 clk_i = ~clk_i;

  wwdt_top dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
    .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .slow_clk_i(slow_clk_i),
    .debug_state_i(debug_state_i), .idle_mode_i(idle_mode_i), .fault_o(fault_o), .irq_o(irq_o),
    .all_reset_req_o(all_reset_req_o), .proc_reset_req_o(proc_reset_req_o));
  wwdt_far_model far (.clk_i(clk_i), .boot_i(boot), .react_i(react), .all_req_i(all_reset_req_o),
    .proc_req_i(proc_reset_req_o), .slow_clk_o(slow_clk_i), .rst_o(rst_i));

  task automatic print_verdict();
    $display("compares %0d bad_count %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : print_verdict

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  // Sampled mid-cycle so the edge's own updates have landed
  task automatic chk_out(input logic [3:0] exp);
    @(negedge clk_i);
    chk("fault irq all proc", {28'h0, exp}, {28'h0, fault_o, irq_o, all_reset_req_o, proc_reset_req_o});
    @(posedge clk_i);
  endtask : chk_out

  // Entered right after a rising edge; the global timeout ends a lost ack
  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= a;
    dat_i <= d;
    do @(posedge clk_i); while (ack_o !== 1'b1);
    rd = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    we_i <= 1'b0;
    @(posedge clk_i);
  endtask : wb

  task automatic rdchk(input string name, input logic [3:0] a, input logic [31:0] exp);
    wb(1'b0, a, 32'h0);
    chk(name, exp, rd);
  endtask : rdchk

  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      bad_count++;
      print_verdict();
    end
  end

  initial begin
    repeat (10) @(posedge clk_i);
    boot <= 1'b0;
    repeat (3) @(posedge clk_i);
    rdchk("mode", WWDT_MODE_OFS, 32'h3FFF_2FFF);
    rdchk("status", WWDT_STATUS_OFS, 32'h0);
    rdchk("unmapped", 4'hC, 32'h0);
    wb(1'b1, WWDT_CONTROL_OFS, 32'hA500_0001);
    chk_out(4'h0);
    rdchk("status", WWDT_STATUS_OFS, 32'h0);
    // Load 3, delta 1, interrupt and general reset on
    wb(1'b1, WWDT_MODE_OFS, 32'h0001_3003);
    wb(1'b1, WWDT_MODE_OFS, 32'h0000_8FFF);
    rdchk("mode", WWDT_MODE_OFS, 32'h0001_3003);
    foreach (bad_keys[i]) wb(1'b1, WWDT_CONTROL_OFS, {bad_keys[i], 24'h1});
    rdchk("status", WWDT_STATUS_OFS, 32'h0);
    wb(1'b1, WWDT_CONTROL_OFS, 32'hA500_0001);
    chk_out(4'hE);
    rdchk("status", WWDT_STATUS_OFS, 32'h2);
    chk_out(4'h0);
    while (fault_o !== 1'b1) @(posedge clk_i);
    rdchk("status", WWDT_STATUS_OFS, 32'h1);
    wb(1'b1, WWDT_CONTROL_OFS, 32'hA500_0001);
    rdchk("status", WWDT_STATUS_OFS, 32'h0);
    // A missed reload would underflow well inside this wait
    repeat (1400) @(posedge clk_i);
    chk_out(4'h0);
    boot <= 1'b1;
    repeat (2) @(posedge clk_i);
    boot <= 1'b0;
    repeat (3) @(posedge clk_i);
    rdchk("mode", WWDT_MODE_OFS, 32'h3FFF_2FFF);
    react <= 1'b1;
    wb(1'b1, WWDT_MODE_OFS, 32'h0001_E003);
    wb(1'b1, WWDT_CONTROL_OFS, 32'hA500_0001);
    chk_out(4'h9);
    repeat (6) @(posedge clk_i);
    rdchk("mode", WWDT_MODE_OFS, 32'h3FFF_2FFF);
    rdchk("status", WWDT_STATUS_OFS, 32'h0);
    // Load 2 with both halt bits; each halted phase outlasts three ticks
    react <= 1'b0;
    wb(1'b1, WWDT_MODE_OFS, 32'h3002_3002);
    debug_state_i <= 1'b1;
    repeat (2000) @(posedge clk_i);
    chk_out(4'h0);
    debug_state_i <= 1'b0;
    idle_mode_i <= 1'b1;
    repeat (2000) @(posedge clk_i);
    chk_out(4'h0);
    idle_mode_i <= 1'b0;
    repeat (2000) @(posedge clk_i);
    chk_out(4'hE);
    rdchk("status", WWDT_STATUS_OFS, 32'h1);
    print_verdict();
  end
endmodule : tb_top
`default_nettype wire
